// ==== logic/lintw_pkg.sv ====
// Package: constants and types for the LIN transceiver control and wake logic
package lintw_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  // Stuck-dominant delay, in ms; nominal figure, window 650 to 1350 ms
  localparam int unsigned STUCK_DOMINANT_DELAY_MS = 1000;
  localparam int unsigned STUCK_DOMINANT_CYCLES =
    (CLK_HZ / 1000) * STUCK_DOMINANT_DELAY_MS;
  // Wake deglitch time, in us; nominal figure, window 42 to 95 us
  localparam int unsigned WAKE_DEGLITCH_TIME_US = 70;
  localparam int unsigned WAKE_DEGLITCH_CYCLES =
    (CLK_HZ / 1000000) * WAKE_DEGLITCH_TIME_US;
  // Stop-mode wake report delay, in us; nominal 13, window 9 to 17 us
  localparam int unsigned WAKE_REPORT_DELAY_US = 13;
  localparam int unsigned WAKE_REPORT_CYCLES =
    (CLK_HZ / 1000000) * WAKE_REPORT_DELAY_US;
  // Sleep-mode supply restart deadline, in us
  localparam int unsigned SUPPLY_RESTART_US = 1500;

  localparam int unsigned TMR_W = 25;

  typedef enum logic [2:0] {
    LINTW_MODE_NORMAL  = 3'b000,
    LINTW_MODE_NORMREQ = 3'b001,
    LINTW_MODE_SLEEP   = 3'b010,
    LINTW_MODE_STOP    = 3'b011,
    LINTW_MODE_RESET   = 3'b100
  } lintw_mode_t;

  typedef enum logic [1:0] {
    LINTW_SLEW_NORMAL = 2'b00,
    LINTW_SLEW_SLOW   = 2'b01,
    LINTW_SLEW_FAST   = 2'b10
  } lintw_slew_t;

  localparam logic [1:0] SLEW_SEL_NORMAL = 2'h0;
  localparam logic [1:0] SLEW_SEL_SLOW   = 2'h1;
endpackage : lintw_pkg

// ==== logic/lintw_filter.sv ====
// Leaf: counts how long a level has held, flags when a limit is reached
`timescale 1ns/1ns
module lintw_filter
  import lintw_pkg::*;
#(
  parameter int unsigned       W     = TMR_W,
  parameter logic [W-1:0]      LIMIT = '1
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic active,
  output logic      reached
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         hit;
  } lintw_flt_t;

  lintw_flt_t st_r;
  lintw_flt_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (!active) begin
      st_nxt.cnt = '0;
      st_nxt.hit = 1'b0;
    end else if (st_r.cnt >= LIMIT - W'(1)) begin
      st_nxt.hit = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + W'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reached = st_r.hit;
endmodule : lintw_filter

// ==== logic/lintw_top.sv ====
// Top: LIN transceiver control, stuck-dominant guard and bus wake logic
`timescale 1ns/1ns
module lintw_top
  import lintw_pkg::*;
#(
  parameter int unsigned STUCK_CYCLES   = STUCK_DOMINANT_CYCLES,
  parameter int unsigned DEGLITCH_CYCLES = WAKE_DEGLITCH_CYCLES
) (
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire lintw_mode_t mode,
  input  wire logic        prog_mode,
  input  wire logic [1:0]  slew_sel,
  input  wire logic        txd_in,
  input  wire logic        txd_driven,
  input  wire logic        lin_bus_in,
  input  wire logic        wake_ack,
  output logic             rxd_out,
  output logic             lin_drv_o,
  output logic             lin_drv_oe,
  output logic             lin_rx_en,
  output lintw_slew_t      slew_mode,
  output logic             stuck_fault,
  output logic             irq_n,
  output logic             wake_flag,
  output logic             vdd_restart
);
  localparam logic [TMR_W-1:0] STUCK_LIM    = TMR_W'(STUCK_CYCLES);
  localparam logic [TMR_W-1:0] DEGLITCH_LIM = TMR_W'(DEGLITCH_CYCLES);
  // Report timer covers only what the deglitch wait has not already spent
  localparam int unsigned RPT_CYCLES =
    (WAKE_REPORT_CYCLES > DEGLITCH_CYCLES) ?
    WAKE_REPORT_CYCLES - DEGLITCH_CYCLES : 0;
  localparam logic [TMR_W-1:0] REPORT_LIM   = TMR_W'(RPT_CYCLES);

  typedef struct packed {
    logic [1:0]   txd_sync;
    logic [1:0]   drv_sync;
    logic [1:0]   bus_sync;
    logic [1:0]   ack_sync;
    logic         ack_prev;
    logic         fault;
    logic         rxd;
    logic         drv;
    logic         oe;
    logic         rx_en;
    logic [1:0]   slew;
    logic         irq;
    logic         wake;
    logic         restart;
    logic         rpt_run;
    logic [TMR_W-1:0] rpt_cnt;
  } lintw_st_t;

  lintw_st_t st_r;
  lintw_st_t st_nxt;
  logic [1:0] rst_sync_r;
  logic      rst_n;
  logic      txd_eff;
  logic      active;
  logic      lowpwr;
  logic      stuck_hit;
  logic      wake_hit;
  logic      ack_pulse;

  // Reset released through two flops; asserted at once
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  assign txd_eff = st_r.drv_sync[1] ? st_r.txd_sync[1] : 1'b1;
  assign active = (mode == LINTW_MODE_NORMAL) ||
                  (mode == LINTW_MODE_NORMREQ);
  assign lowpwr = (mode == LINTW_MODE_SLEEP) || (mode == LINTW_MODE_STOP);
  assign ack_pulse = st_r.ack_sync[1] && !st_r.ack_prev;

  lintw_filter #(
    .W     (TMR_W),
    .LIMIT (STUCK_LIM)
  ) u_stuck (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .active  (active && !txd_eff),
    .reached (stuck_hit)
  );

  lintw_filter #(
    .W     (TMR_W),
    .LIMIT (DEGLITCH_LIM)
  ) u_wake (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .active  (lowpwr && !st_r.bus_sync[1]),
    .reached (wake_hit)
  );

  always_comb begin
    st_nxt          = st_r;
    st_nxt.txd_sync = {st_r.txd_sync[0], txd_in};
    st_nxt.drv_sync = {st_r.drv_sync[0], txd_driven};
    st_nxt.bus_sync = {st_r.bus_sync[0], lin_bus_in};
    st_nxt.ack_sync = {st_r.ack_sync[0], wake_ack};
    st_nxt.ack_prev = st_r.ack_sync[1];

    if (txd_eff || !active) begin
      st_nxt.fault = 1'b0;
    end else if (stuck_hit) begin
      st_nxt.fault = 1'b1;
    end

    st_nxt.drv   = active && !txd_eff && !(st_r.fault || stuck_hit);
    st_nxt.oe    = st_nxt.drv;
    st_nxt.rx_en = active;
    st_nxt.rxd   = active ? st_r.bus_sync[1] : 1'b1;

    if (prog_mode) begin
      st_nxt.slew = LINTW_SLEW_FAST;
    end else if (slew_sel == SLEW_SEL_SLOW) begin
      st_nxt.slew = LINTW_SLEW_SLOW;
    end else begin
      st_nxt.slew = LINTW_SLEW_NORMAL;
    end

    // Wake counted from deglitch, report timer started in stop
    st_nxt.restart = 1'b0;
    if (wake_hit && !st_r.wake) begin
      st_nxt.wake = 1'b1;
      case (mode)
        LINTW_MODE_STOP: begin
          st_nxt.rpt_run = 1'b1;
          st_nxt.rpt_cnt = '0;
        end
        LINTW_MODE_SLEEP: begin
          st_nxt.restart = 1'b1;
        end
        default: begin
          st_nxt.rpt_run = st_r.rpt_run;
        end
      endcase
    end else if (ack_pulse && !st_r.rpt_run) begin
      st_nxt.wake = 1'b0;
    end

    if (st_r.rpt_run) begin
      if (st_r.rpt_cnt >= REPORT_LIM) begin
        st_nxt.rpt_run = 1'b0;
        st_nxt.irq     = 1'b1;
      end else begin
        st_nxt.rpt_cnt = st_r.rpt_cnt + TMR_W'(1);
      end
    end else if (ack_pulse) begin
      st_nxt.irq = 1'b0;
    end
  end

  // Held in reset until the synchronised release
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_r.txd_sync <= 2'h3;
      st_r.drv_sync <= 2'h0;
      st_r.bus_sync <= 2'h3;
      st_r.ack_sync <= 2'h0;
      st_r.ack_prev <= 1'b0;
      st_r.fault    <= 1'b0;
      st_r.rxd      <= 1'b1;
      st_r.drv      <= 1'b0;
      st_r.oe       <= 1'b0;
      st_r.rx_en    <= 1'b0;
      st_r.slew     <= 2'h0;
      st_r.irq      <= 1'b0;
      st_r.wake     <= 1'b0;
      st_r.restart  <= 1'b0;
      st_r.rpt_run  <= 1'b0;
      st_r.rpt_cnt  <= '0;
    end else begin
      st_r.txd_sync <= st_nxt.txd_sync;
      st_r.drv_sync <= st_nxt.drv_sync;
      st_r.bus_sync <= st_nxt.bus_sync;
      st_r.ack_sync <= st_nxt.ack_sync;
      st_r.ack_prev <= st_nxt.ack_prev;
      st_r.fault    <= st_nxt.fault;
      st_r.rxd      <= st_nxt.rxd;
      st_r.drv      <= st_nxt.drv;
      st_r.oe       <= st_nxt.oe;
      st_r.rx_en    <= st_nxt.rx_en;
      st_r.slew     <= st_nxt.slew;
      st_r.irq      <= st_nxt.irq;
      st_r.wake     <= st_nxt.wake;
      st_r.restart  <= st_nxt.restart;
      st_r.rpt_run  <= st_nxt.rpt_run;
      st_r.rpt_cnt  <= st_nxt.rpt_cnt;
    end
  end

  assign rxd_out     = st_r.rxd;
  assign lin_drv_o   = 1'b0;
  assign lin_drv_oe  = st_r.oe;
  assign lin_rx_en   = st_r.rx_en;
  assign slew_mode   = lintw_slew_t'(st_r.slew);
  assign stuck_fault = st_r.fault;
  assign irq_n       = !st_r.irq;
  assign wake_flag   = st_r.wake;
  assign vdd_restart = st_r.restart;
endmodule : lintw_top

// ==== tb/lintw_top_assertions.sv ====
// Port checker for the LIN transceiver control and wake logic
`timescale 1ns/1ns
module lintw_top_assertions
  import lintw_pkg::*;
#(
  parameter int unsigned STUCK_CYCLES    = STUCK_DOMINANT_CYCLES,
  parameter int unsigned DEGLITCH_CYCLES = WAKE_DEGLITCH_CYCLES
) (
  input wire logic        clk_sys,
  input wire logic        arst_n,
  input wire lintw_mode_t mode,
  input wire logic        txd_in,
  input wire logic        txd_driven,
  input wire logic        lin_bus_in,
  input wire logic        wake_ack,
  input wire logic        rxd_out,
  input wire logic        lin_drv_oe,
  input wire logic        lin_rx_en,
  input wire logic        stuck_fault,
  input wire logic        irq_n,
  input wire logic        wake_flag,
  input wire logic        vdd_restart
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // Report timer only adds delay past one cycle where deglitch is shorter than report delay
  localparam int RPT_LO = (WAKE_REPORT_CYCLES > DEGLITCH_CYCLES) ?
    WAKE_REPORT_CYCLES - DEGLITCH_CYCLES + 1 : 1;
  localparam int RPT_HI = RPT_LO + 2;
  logic        act;
  logic        tx_dom;
  logic        low_pwr;
  logic [5:0]  ack_sh;
  logic [31:0] dom_cnt;
  logic [31:0] low_cnt;
  assign act = mode == LINTW_MODE_NORMAL || mode == LINTW_MODE_NORMREQ;
  assign low_pwr = mode == LINTW_MODE_SLEEP || mode == LINTW_MODE_STOP;
  assign tx_dom = act && !txd_in && txd_driven;
  // Raw run lengths; the design sees them two cycles late
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ack_sh  <= '0;
      dom_cnt <= '0;
      low_cnt <= '0;
    end else begin
      ack_sh  <= {ack_sh[4:0], wake_ack};
      dom_cnt <= tx_dom ? dom_cnt + 1 : '0;
      low_cnt <= (low_pwr && !lin_bus_in) ? low_cnt + 1 : '0;
    end
  end
  sequence wake_in(lintw_mode_t m);
    $rose(wake_flag) && mode == m;
  endsequence
  mode_gate_a: assert property (lin_drv_oe || lin_rx_en |-> $past(act))
    else $error("transceiver on outside normal modes");
  tx_dom_a: assert property ((tx_dom && !stuck_fault)[*5]
    |-> lin_drv_oe) else $error("bus not driven dominant");
  tx_rec_a: assert property ((txd_in || !txd_driven)[*5]
    |-> !lin_drv_oe) else $error("bus driven while input recessive");
  rx_lvl_a: assert property ((act && $stable(lin_bus_in))[*6]
    |-> rxd_out == lin_bus_in) else $error("receive level wrong");
  stuck_a: assert property ($rose(stuck_fault)
    |-> dom_cnt >= STUCK_CYCLES) else $error("stuck fault too early");
  deglitch_a: assert property ($rose(wake_flag)
    |-> low_cnt >= DEGLITCH_CYCLES)
    else $error("wake accepted before deglitch");
  stop_irq_a: assert property (wake_in(LINTW_MODE_STOP)
    |-> ##[RPT_LO:RPT_HI] !irq_n) else $error("stop wake without interrupt");
  sleep_rst_a: assert property (wake_in(LINTW_MODE_SLEEP)
    |-> ##[0:3] vdd_restart ##1 !vdd_restart) else $error("no supply restart");
  irq_hold_a: assert property ($rose(irq_n) |-> |ack_sh)
    else $error("interrupt released without acknowledge");
endmodule : lintw_top_assertions
bind lintw_top lintw_top_assertions #(.STUCK_CYCLES(STUCK_CYCLES),
  .DEGLITCH_CYCLES(DEGLITCH_CYCLES)) lintw_top_assertions_i (
  .clk_sys(clk_sys), .arst_n(arst_n), .mode(mode), .txd_in(txd_in),
  .txd_driven(txd_driven), .lin_bus_in(lin_bus_in), .wake_ack(wake_ack),
  .rxd_out(rxd_out), .lin_drv_oe(lin_drv_oe), .lin_rx_en(lin_rx_en),
  .stuck_fault(stuck_fault), .irq_n(irq_n), .wake_flag(wake_flag),
  .vdd_restart(vdd_restart));

// ==== tb/lintw_lin_node.sv ====
// Far-side LIN node and the shared bus wire
`timescale 1ns/1ns
module lintw_lin_node (
  input  wire logic drv_oe,
  input  wire logic drv_o,
  input  wire logic node_dom,
  output logic      lin_bus
);
  // Wired-AND: any dominant driver wins, pull-up gives recessive
  assign lin_bus = ((drv_oe && !drv_o) || node_dom) ? 1'b0 : 1'b1;
endmodule : lintw_lin_node

// ==== tb/tb_lintw_top.sv ====
// Testbench for the LIN transceiver control and wake logic
`timescale 1ns/1ns
module tb_lintw_top;
  import lintw_pkg::*;
  localparam int unsigned SC = 200;
  // Deglitch longer than report delay, as with the defaults
  localparam int unsigned DC = 400;
  logic        clk_sys = 1'b0, arst_n = 1'b0, prog_mode = 1'b0;
  logic        txd_in = 1'b1, txd_driven = 1'b1, wake_ack = 1'b0;
  logic        node_dom = 1'b0, b;
  logic        lin_bus, rxd_out, lin_drv_o, lin_drv_oe, lin_rx_en;
  logic        stuck_fault, irq_n, wake_flag, vdd_restart;
  logic [1:0]  slew_sel = 2'h0;
  lintw_mode_t mode = LINTW_MODE_NORMAL;
  lintw_slew_t slew_mode;
  int          n_mismatch = 0, num_checks = 0, seed = 32'hdd44, k;
  initial forever #20 clk_sys = ~clk_sys;
  lintw_top #(.STUCK_CYCLES(SC), .DEGLITCH_CYCLES(DC)) lintw_top_i (
    .clk_sys(clk_sys), .arst_n(arst_n), .mode(mode), .prog_mode(prog_mode),
    .slew_sel(slew_sel), .txd_in(txd_in), .txd_driven(txd_driven),
    .lin_bus_in(lin_bus), .wake_ack(wake_ack), .rxd_out(rxd_out),
    .lin_drv_o(lin_drv_o), .lin_drv_oe(lin_drv_oe), .lin_rx_en(lin_rx_en),
    .slew_mode(slew_mode), .stuck_fault(stuck_fault), .irq_n(irq_n),
    .wake_flag(wake_flag), .vdd_restart(vdd_restart));
  lintw_lin_node lintw_lin_node_i (.drv_oe(lin_drv_oe), .drv_o(lin_drv_o),
    .node_dom(node_dom), .lin_bus(lin_bus));
  task automatic chk(input string nm, input logic e, input logic s);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %b seen %b", nm, e, s);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc
  function automatic logic act(input lintw_mode_t m);
    return m == LINTW_MODE_NORMAL || m == LINTW_MODE_NORMREQ;
  endfunction : act
  task automatic wake(input lintw_mode_t m);
    int p;
    mode = m;
    node_dom = 1'b1;
    cyc(DC - 6);
    node_dom = 1'b0;
    cyc(8);
    chk("glitch", 1'b0, wake_flag);
    node_dom = 1'b1;
    p = 0;
    repeat (DC + 8) begin
      cyc(1);
      p += vdd_restart;
    end
    node_dom = 1'b0;
    chk("wake", 1'b1, wake_flag);
    chk("irq", m != LINTW_MODE_STOP, irq_n);
    chk("restart", m == LINTW_MODE_SLEEP, p == 1);
    cyc(10);
    chk("irq hold", m != LINTW_MODE_STOP, irq_n);
    wake_ack = 1'b1;
    cyc(2);
    wake_ack = 1'b0;
    cyc(6);
    chk("irq ack", 1'b1, irq_n);
    chk("flag ack", 1'b0, wake_flag);
  endtask : wake
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  initial begin
    cyc(6);
    arst_n = 1'b1;
    cyc(4);
    // Random frames; holds long enough for the txd, drive and bus synchronisers
    repeat (150) begin
      txd_in = 1'($random(seed));
      txd_driven = ($random(seed) % 4) != 0;
      node_dom = ($random(seed) % 3) == 0;
      cyc(8 + {$random(seed)} % 5);
      b = !txd_in && txd_driven;
      chk("drive", b, lin_drv_oe);
      chk("rxd", !(b || node_dom), rxd_out);
      chk("drv lvl", 1'b0, lin_drv_o);
    end
    node_dom = 1'b0;
    txd_driven = 1'b1;
    txd_in = 1'b0;
    for (k = 0; k < 5; k++) begin
      mode = lintw_mode_t'(k);
      cyc(5);
      chk("oe mode", act(mode), lin_drv_oe);
      chk("rx en", act(mode), lin_rx_en);
    end
    mode = LINTW_MODE_NORMAL;
    cyc(SC + 8);
    chk("fault", 1'b1, stuck_fault);
    chk("forced", 1'b0, lin_drv_oe);
    txd_in = 1'b1;
    cyc(6);
    chk("fault clr", 1'b0, stuck_fault);
    wake(LINTW_MODE_STOP);
    wake(LINTW_MODE_SLEEP);
    for (k = 0; k < 8; k++) begin
      {prog_mode, slew_sel} = 3'(k);
      cyc(3);
      b = prog_mode ? slew_mode === LINTW_SLEW_FAST :
          slew_sel == SLEW_SEL_SLOW ? slew_mode === LINTW_SLEW_SLOW :
          slew_mode === LINTW_SLEW_NORMAL;
      chk("slew", 1'b1, b);
    end
    end_of_test();
  end
  initial begin
    #(40 * 20000);
    n_mismatch++;
    end_of_test();
  end
endmodule : tb_lintw_top
